// ---- include/fpac_defs.svh ----
`ifndef FPAC_DEFS_SVH
`define FPAC_DEFS_SVH

// ****************************************************
// command codes seen on the serial link
// ****************************************************
`define FPAC_OP_LATCH_SET 8'h06
`define FPAC_OP_LATCH_CLR 8'h04
`define FPAC_OP_STATUS_WRITE 8'h01
`define FPAC_OP_STATUS_READ 8'h05
`define FPAC_OP_CFG_READ 8'h15
`define FPAC_OP_SEC_READ 8'h2b
`define FPAC_OP_SEC_WRITE 8'h2f
`define FPAC_OP_OTP_ENTER 8'hb1
`define FPAC_OP_OTP_EXIT 8'hc1
`define FPAC_OP_READ 8'h03
`define FPAC_OP_FAST_READ 8'h0b
`define FPAC_OP_PROG 8'h02
`define FPAC_OP_ERASE_4K 8'h20
`define FPAC_OP_ERASE_32K 8'h52
`define FPAC_OP_ERASE_64K 8'hd8
`define FPAC_OP_CHIP_ERASE_A 8'h60
`define FPAC_OP_CHIP_ERASE_B 8'hc7

// ****************************************************
// field positions, widths, lengths and reset values
// ****************************************************
`define FPAC_ST_BUSY 0
`define FPAC_ST_WLATCH 1
`define FPAC_ST_BP_LSB 2
`define FPAC_ST_QE 6
`define FPAC_ST_GUARD 7
`define FPAC_CFG_TB 3
`define FPAC_SEC_FACTORY 0
`define FPAC_SEC_CUST 1
`define FPAC_OTP_ROW_BIT 9
`define FPAC_BLK_LSB 16
`define FPAC_ADDR_W 24
`define FPAC_NUM_BLOCKS 16
`define FPAC_LEVEL_W 4
`define FPAC_MAX_PART_LEVEL 4
`define FPAC_LEN_CMD 3'h1
`define FPAC_LEN_ST_MIN 3'h2
`define FPAC_LEN_ST_CFG 3'h3
`define FPAC_LEN_ADDR 3'h4
`define FPAC_LEN_PROG 3'h5
`define FPAC_LEN_SAT 3'h7
`define FPAC_STATUS_RST 8'h00
`define FPAC_CFG_RST 8'h00

`endif

// ---- include/fpac_pkg.sv ----
`include "fpac_defs.svh"

package fpac_pkg;

	// link-side frame state; order keeps every step a one-bit change
	typedef enum logic [1:0] {
		FPAC_LK_CMD,
		FPAC_LK_ACTIVE,
		FPAC_LK_STANDBY
	} fpac_link_st_t;

	// kind of array operation handed to the program/erase engine
	typedef enum logic [2:0] {
		FPAC_K_NONE,
		FPAC_K_PROG,
		FPAC_K_ERASE_4K,
		FPAC_K_ERASE_32K,
		FPAC_K_ERASE_64K,
		FPAC_K_CHIP
	} fpac_kind_t;

	// one received frame as captured on the serial clock
	typedef struct packed {
		logic [7:0] opcode;
		logic [`FPAC_ADDR_W-1:0] addr;
		logic [2:0] byte_cnt;
		logic [2:0] bit_lo;
	} fpac_frame_t;

	// block protection setting
	typedef struct packed {
		logic [`FPAC_LEVEL_W-1:0] level;
		logic protect_from_bottom;
	} fpac_prot_cfg_t;

	// request to the program/erase engine
	typedef struct packed {
		fpac_kind_t kind;
		logic [`FPAC_ADDR_W-1:0] addr;
		logic otp;
	} fpac_op_req_t;

endpackage : fpac_pkg

// ---- hw/fpac_prot_decode.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "fpac_defs.svh"

module fpac_prot_decode #(
	parameter int NUM_BLOCKS = `FPAC_NUM_BLOCKS,
	parameter int BLK_W = $clog2(`FPAC_NUM_BLOCKS)
) (
	input wire fpac_pkg::fpac_prot_cfg_t cfg_i, // protect level and side
	input wire logic [BLK_W-1:0] blk_i, // block under test
	output logic [NUM_BLOCKS-1:0] mask_o, // one bit per protected block
	output logic hit_o, // block under test is protected
	output logic any_o // some block is protected
);

	// ****************************************************
	// elaboration check
	// ****************************************************
	// the partial levels reach eight blocks, so fewer cannot serve
	if (NUM_BLOCKS < 8 || (1 << BLK_W) != NUM_BLOCKS) begin : g_bad
		$error("fpac_prot_decode: NUM_BLOCKS must be a power of two >= 8");
	end

	// ****************************************************
	// protected block count
	// ****************************************************
	logic [BLK_W:0] count;

	// levels 1..4 give 1,2,4,8 blocks, anything above covers all
	always_comb begin
		if (cfg_i.level == '0) begin
			count = '0;
		end else if (cfg_i.level <= `FPAC_LEVEL_W'(`FPAC_MAX_PART_LEVEL)) begin
			count = (BLK_W+1)'(1) << (cfg_i.level - `FPAC_LEVEL_W'(1));
		end else begin
			count = (BLK_W+1)'(NUM_BLOCKS);
		end
	end

	// ****************************************************
	// per-block mask
	// ****************************************************
	for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_blk
		// bottom side counts up from block 0, top side down from the last
		always_comb begin
			if (cfg_i.protect_from_bottom) begin
				mask_o[b] = (BLK_W+1)'(b) < count;
			end else begin
				mask_o[b] = (BLK_W+1)'(b) >= (BLK_W+1)'(NUM_BLOCKS) - count;
			end
		end
	end

	// lookups for the command checks
	assign hit_o = mask_o[blk_i];
	assign any_o = |mask_o;

endmodule : fpac_prot_decode
`default_nettype wire

// ---- hw/fpac_access_ctl.sv ----
// Function
// - top side protects highest 1/2/4/8 blocks
// - bottom side protects lowest 1/2/4/8 blocks
// - level 0 none, levels 5-15 all
// - chip erase only when protect level zero
// - two OTP rows, selected by offset bit
// - security bit 0 shows factory row lock
// - security write command sets customer lock bit1
// - locked OTP row refuses every change
// - OTP mode blocks main array access
// - invalid command: standby, output off
// - valid command: active until deselect
// - sample rising edge, shift on falling
// - clock may idle low or high
// - read commands end cleanly at deselect
// - write commands must end on byte boundary
// - busy device ignores array changes
// - data changes need write latch set
// - write-protect pin guards protect bits, except in quad mode
`timescale 1ns/10ps
`default_nettype none
`include "fpac_defs.svh"

module fpac_access_ctl #(
	parameter int NUM_BLOCKS = `FPAC_NUM_BLOCKS
) (
	input wire logic sys_clk_i, // system clock, 200 MHz
	input wire logic reset_n_i, // reset, active low; synchronous in the system domain, asynchronous in the link domain
	input wire logic sclk_i, // serial clock from host
	input wire logic cs_n_i, // chip select, active low
	input wire logic si_i, // serial data in
	input wire logic wp_n_i, // write-protect pin, active low
	input wire logic busy_i, // program/erase/status write running
	input wire logic factory_lock_i, // factory row lock, stored
	input wire logic cust_lock_nv_i, // customer row lock, stored
	output logic so_o, // serial data out
	output logic so_oe_o, // serial data out enable
	output fpac_pkg::fpac_op_req_t op_req_o, // request to engine
	output logic op_req_valid_o, // request pulse
	output logic cmd_reject_o, // refused command pulse
	output logic array_read_en_o, // array reads allowed
	output logic otp_mode_o, // OTP mode active
	output logic [7:0] status_o, // status byte
	output logic [7:0] security_o, // security byte
	output logic [NUM_BLOCKS-1:0] prot_mask_o, // protected blocks
	output logic mode_active_o, // valid command in frame
	output logic standby_o // invalid command in frame
);

	localparam int BLK_W = $clog2(NUM_BLOCKS);

	// ****************************************************
	// command classes
	// ****************************************************
	function automatic logic known_cmd(input logic [7:0] op);
		case (op)
			`FPAC_OP_LATCH_SET, `FPAC_OP_LATCH_CLR, `FPAC_OP_STATUS_WRITE,
			`FPAC_OP_STATUS_READ, `FPAC_OP_CFG_READ, `FPAC_OP_SEC_READ,
			`FPAC_OP_SEC_WRITE, `FPAC_OP_OTP_ENTER, `FPAC_OP_OTP_EXIT,
			`FPAC_OP_READ, `FPAC_OP_FAST_READ, `FPAC_OP_PROG,
			`FPAC_OP_ERASE_4K, `FPAC_OP_ERASE_32K, `FPAC_OP_ERASE_64K,
			`FPAC_OP_CHIP_ERASE_A, `FPAC_OP_CHIP_ERASE_B: known_cmd = 1'b1;
			default: known_cmd = 1'b0;
		endcase
	endfunction : known_cmd

	function automatic logic reg_read(input logic [7:0] op);
		reg_read = (op == `FPAC_OP_STATUS_READ) ||
			(op == `FPAC_OP_CFG_READ) || (op == `FPAC_OP_SEC_READ);
	endfunction : reg_read

	// ****************************************************
	// link domain: frame capture
	// ****************************************************
	fpac_pkg::fpac_frame_t frame;
	fpac_pkg::fpac_link_st_t link_st;
	logic first_edge;
	logic [7:0] shift_in;
	logic [2:0] cur_lo;
	logic [2:0] cur_bytes;
	logic byte_done;
	logic [7:0] in_byte;

	// marks the first clock of a frame; deselect rearms it
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			first_edge <= 1'b1;
		end else begin
			first_edge <= 1'b0;
		end
	end

	// counts restart with the frame without needing a clock after it
	always_comb begin
		cur_lo = first_edge ? 3'h0 : frame.bit_lo;
		cur_bytes = first_edge ? 3'h0 : frame.byte_cnt;
		byte_done = (cur_lo == 3'h7);
		in_byte = {shift_in[6:0], si_i};
	end

	// the idle level of the clock does not matter: only rising edges load
	always_ff @(posedge sclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			frame <= '0;
			shift_in <= 8'h00;
		end else begin
			shift_in <= in_byte;
			frame.bit_lo <= cur_lo + 3'h1;
			if (byte_done && cur_bytes != `FPAC_LEN_SAT) begin
				frame.byte_cnt <= cur_bytes + 3'h1;
			end else begin
				frame.byte_cnt <= cur_bytes;
			end
			if (byte_done) begin
				case (cur_bytes)
					3'h0: frame.opcode <= in_byte;
					3'h1: frame.addr[23:16] <= in_byte;
					3'h2: frame.addr[15:8] <= in_byte;
					3'h3: frame.addr[7:0] <= in_byte;
					default: ; // data bytes are not kept here
				endcase
			end
		end
	end

	// frame state: deselect returns to command phase
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			link_st <= fpac_pkg::FPAC_LK_CMD;
		end else begin
			unique case (link_st)
				fpac_pkg::FPAC_LK_CMD: begin
					if (byte_done && cur_bytes == 3'h0) begin
						if (known_cmd(in_byte)) begin
							link_st <= fpac_pkg::FPAC_LK_ACTIVE;
						end else begin
							link_st <= fpac_pkg::FPAC_LK_STANDBY;
						end
					end
				end
				fpac_pkg::FPAC_LK_ACTIVE: link_st <= link_st;
				fpac_pkg::FPAC_LK_STANDBY: link_st <= link_st;
			endcase
		end
	end

	// ****************************************************
	// link domain: register read-out
	// ****************************************************
	logic [23:0] view_meta;
	logic [23:0] view_sync;
	logic [7:0] sel_byte;
	logic [2:0] out_idx;
	logic so_q;
	logic oe_q;
	logic [7:0] cfg_byte;

	// register bytes change rarely; a read racing an update may mix
	// old and new bits, which a following status poll corrects
	always_ff @(posedge sclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			view_meta <= 24'h000000;
			view_sync <= 24'h000000;
		end else begin
			view_meta <= {status_o, cfg_byte, security_o};
			view_sync <= view_meta;
		end
	end

	// byte returned by the current read command
	always_comb begin
		case (frame.opcode)
			`FPAC_OP_STATUS_READ: sel_byte = view_sync[23:16];
			`FPAC_OP_CFG_READ: sel_byte = view_sync[15:8];
			default: sel_byte = view_sync[7:0];
		endcase
	end

	// output shifts on the falling edge; deselect drops it at once
	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			out_idx <= 3'h0;
			so_q <= 1'b0;
			oe_q <= 1'b0;
		end else if (link_st == fpac_pkg::FPAC_LK_ACTIVE &&
			reg_read(frame.opcode)) begin
			so_q <= sel_byte[3'h7 - out_idx];
			out_idx <= out_idx + 3'h1;
			oe_q <= 1'b1;
		end else begin
			oe_q <= 1'b0;
		end
	end

	assign so_o = so_q;
	assign so_oe_o = oe_q;

	// ****************************************************
	// system domain: pin and state synchronisers
	// ****************************************************
	logic [2:0] cs_sync;
	logic [1:0] wp_sync;
	logic [1:0] st_meta;
	logic [1:0] st_sync;
	logic frame_end;

	// second stage onward feeds logic; first stage feeds only the next
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			cs_sync <= 3'h7;
			wp_sync <= 2'h3;
			st_meta <= 2'h0;
			st_sync <= 2'h0;
		end else begin
			cs_sync <= {cs_sync[1:0], cs_n_i};
			wp_sync <= {wp_sync[0], wp_n_i};
			st_meta <= link_st;
			st_sync <= st_meta;
		end
	end

	// frame words are static once the clock stops around deselect
	assign frame_end = cs_sync[1] & ~cs_sync[2];
	assign mode_active_o = (st_sync == fpac_pkg::FPAC_LK_ACTIVE);
	assign standby_o = (st_sync == fpac_pkg::FPAC_LK_STANDBY);

	// ****************************************************
	// system domain: protection state
	// ****************************************************
	fpac_pkg::fpac_prot_cfg_t prot_cfg;
	logic wlatch;
	logic guard;
	logic quad_en;
	logic cust_lock;
	logic otp_mode;
	logic addr_blocked;
	logic hw_lock;

	fpac_prot_decode #(
		.NUM_BLOCKS(NUM_BLOCKS),
		.BLK_W(BLK_W)
	) u_decode (
		.cfg_i(prot_cfg),
		.blk_i(frame.addr[`FPAC_BLK_LSB +: BLK_W]),
		.mask_o(prot_mask_o),
		.hit_o(addr_blocked),
		.any_o()
	);

	// pin guard is off while quad mode uses the pin for data
	assign hw_lock = guard & ~wp_sync[1] & ~quad_en;

	// visible register bytes
	always_comb begin
		status_o = `FPAC_STATUS_RST;
		status_o[`FPAC_ST_BUSY] = busy_i;
		status_o[`FPAC_ST_WLATCH] = wlatch;
		status_o[`FPAC_ST_BP_LSB +: `FPAC_LEVEL_W] = prot_cfg.level;
		status_o[`FPAC_ST_QE] = quad_en;
		status_o[`FPAC_ST_GUARD] = guard;
		cfg_byte = `FPAC_CFG_RST;
		cfg_byte[`FPAC_CFG_TB] = prot_cfg.protect_from_bottom;
		security_o = 8'h00;
		security_o[`FPAC_SEC_FACTORY] = factory_lock_i;
		security_o[`FPAC_SEC_CUST] = cust_lock;
	end

	// ****************************************************
	// system domain: command acceptance
	// ****************************************************
	logic on_bound;
	logic len_cmd;
	logic row_locked;
	logic do_set;
	logic do_clr;
	logic do_status;
	logic do_sec;
	logic do_enter;
	logic do_exit;
	logic do_req;
	logic do_reject;
	fpac_pkg::fpac_kind_t req_kind;

	// every non-read command needs a whole-byte frame; status, security and array changes also need latch and idle engine
	always_comb begin
		on_bound = (frame.bit_lo == 3'h0);
		len_cmd = on_bound && frame.byte_cnt == `FPAC_LEN_CMD;
		row_locked = frame.addr[`FPAC_OTP_ROW_BIT] ?
			factory_lock_i : cust_lock;
		do_set = 1'b0;
		do_clr = 1'b0;
		do_status = 1'b0;
		do_sec = 1'b0;
		do_enter = 1'b0;
		do_exit = 1'b0;
		do_req = 1'b0;
		do_reject = 1'b0;
		req_kind = fpac_pkg::FPAC_K_NONE;
		// synced link state is back in command phase by now; a whole
		// opcode byte in the frame count qualifies the frame instead
		if (frame_end && frame.byte_cnt != 3'h0) begin
			case (frame.opcode)
				`FPAC_OP_LATCH_SET: begin
					do_set = len_cmd;
					do_reject = !len_cmd;
				end
				`FPAC_OP_LATCH_CLR: begin
					do_clr = len_cmd;
					do_reject = !len_cmd;
				end
				`FPAC_OP_STATUS_WRITE: begin
					do_status = on_bound && wlatch && !busy_i &&
						(frame.byte_cnt == `FPAC_LEN_ST_MIN ||
						frame.byte_cnt == `FPAC_LEN_ST_CFG);
					do_reject = !do_status;
				end
				`FPAC_OP_SEC_WRITE: begin
					do_sec = len_cmd && wlatch && !busy_i;
					do_reject = !do_sec;
				end
				`FPAC_OP_OTP_ENTER: begin
					do_enter = len_cmd;
					do_reject = !len_cmd;
				end
				`FPAC_OP_OTP_EXIT: begin
					do_exit = len_cmd;
					do_reject = !len_cmd;
				end
				`FPAC_OP_CHIP_ERASE_A, `FPAC_OP_CHIP_ERASE_B: begin
					req_kind = fpac_pkg::FPAC_K_CHIP;
					do_req = len_cmd && wlatch && !busy_i && !otp_mode &&
						prot_cfg.level == '0;
					do_reject = !do_req;
				end
				`FPAC_OP_ERASE_4K, `FPAC_OP_ERASE_32K, `FPAC_OP_ERASE_64K: begin
					if (frame.opcode == `FPAC_OP_ERASE_4K) begin
						req_kind = fpac_pkg::FPAC_K_ERASE_4K;
					end else if (frame.opcode == `FPAC_OP_ERASE_32K) begin
						req_kind = fpac_pkg::FPAC_K_ERASE_32K;
					end else begin
						req_kind = fpac_pkg::FPAC_K_ERASE_64K;
					end
					do_req = on_bound && frame.byte_cnt == `FPAC_LEN_ADDR &&
						wlatch && !busy_i && !otp_mode &&
						!addr_blocked;
					do_reject = !do_req;
				end
				`FPAC_OP_PROG: begin
					req_kind = fpac_pkg::FPAC_K_PROG;
					do_req = on_bound && frame.byte_cnt >= `FPAC_LEN_PROG &&
						wlatch && !busy_i &&
						(otp_mode ? !row_locked : !addr_blocked);
					do_reject = !do_req;
				end
				default: ; // reads need no action at deselect
			endcase
		end
	end

	// ****************************************************
	// system domain: state updates
	// ****************************************************
	// latch set by its own command, cleared by any accepted change
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			wlatch <= 1'b0;
		end else if (do_set) begin
			wlatch <= 1'b1;
		end else if (do_clr || do_status || do_sec || do_req) begin
			wlatch <= 1'b0;
		end
	end

	// protect bits and guard stay frozen under the pin guard
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			prot_cfg.level <= `FPAC_LEVEL_W'(`FPAC_STATUS_RST >>
				`FPAC_ST_BP_LSB);
			guard <= 1'(`FPAC_STATUS_RST >> `FPAC_ST_GUARD);
			quad_en <= 1'(`FPAC_STATUS_RST >> `FPAC_ST_QE);
			prot_cfg.protect_from_bottom <= 1'(`FPAC_CFG_RST >>
				`FPAC_CFG_TB);
		end else if (do_status) begin
			quad_en <= frame.addr[16 + `FPAC_ST_QE];
			if (!hw_lock) begin
				prot_cfg.level <= frame.addr[16 + `FPAC_ST_BP_LSB +:
					`FPAC_LEVEL_W];
				guard <= frame.addr[16 + `FPAC_ST_GUARD];
			end
			if (frame.byte_cnt == `FPAC_LEN_ST_CFG) begin
				prot_cfg.protect_from_bottom <= frame.addr[8 + `FPAC_CFG_TB];
			end
		end
	end

	// customer lock is one-way; stored value reloads during reset
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			cust_lock <= cust_lock_nv_i;
		end else if (do_sec) begin
			cust_lock <= 1'b1;
		end
	end

	// OTP mode between its enter and exit commands
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			otp_mode <= 1'b0;
		end else if (do_enter) begin
			otp_mode <= 1'b1;
		end else if (do_exit) begin
			otp_mode <= 1'b0;
		end
	end

	// engine request and refusal pulses
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			op_req_o <= '0;
			op_req_valid_o <= 1'b0;
			cmd_reject_o <= 1'b0;
		end else begin
			op_req_valid_o <= do_req;
			cmd_reject_o <= do_reject;
			if (do_req) begin
				op_req_o.kind <= req_kind;
				op_req_o.addr <= frame.addr;
				op_req_o.otp <= otp_mode;
			end
		end
	end

	// array reads stop while busy or in OTP mode
	assign array_read_en_o = !busy_i && !otp_mode;
	assign otp_mode_o = otp_mode;

endmodule : fpac_access_ctl
`default_nettype wire

// ---- tb/fpac_access_ctl_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "fpac_defs.svh"

module fpac_access_ctl_asserts #(
	parameter int NUM_BLOCKS = 16
) (
	input wire logic sys_clk_i, // system clock
	input wire logic reset_n_i, // sync reset, active low
	input wire logic cs_n_i, // chip select
	input wire logic busy_i, // engine busy
	input wire logic factory_lock_i, // factory row lock
	input wire logic so_oe_o, // serial out enable
	input wire fpac_pkg::fpac_op_req_t op_req_o, // engine request
	input wire logic op_req_valid_o, // request pulse
	input wire logic cmd_reject_o, // refusal pulse
	input wire logic array_read_en_o, // array reads allowed
	input wire logic otp_mode_o, // otp mode
	input wire logic [7:0] status_o, // status byte
	input wire logic [7:0] security_o, // security byte
	input wire logic [NUM_BLOCKS-1:0] prot_mask_o // protected blocks
);
	// ****
	// helper masks
	// ****
	int n;
	logic [3:0] lvl;
	logic [NUM_BLOCKS-1:0] bot;
	logic [NUM_BLOCKS-1:0] top;
	// side is not visible here, so a partial mask may sit at either end
	always_comb begin
		lvl = status_o[5:2];
		n = (lvl == 4'h0) ? 0 : 1 << (lvl - 4'h1);
		for (int i = 0; i < NUM_BLOCKS; i++) begin
			bot[i] = i < n;
			top[i] = i >= NUM_BLOCKS - n;
		end
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	// ****
	// properties
	// ****
	chk_level_none: assert property (lvl == 4'h0 |-> prot_mask_o == '0)
		else $error("mask not empty at level zero");
	chk_level_all: assert property (lvl > 4'h4 |-> &prot_mask_o)
		else $error("mask not full at high level");
	chk_level_part: assert property (lvl inside {[4'h1:4'h4]}
		|-> prot_mask_o == top || prot_mask_o == bot)
		else $error("partial mask has wrong shape");
	chk_chip_gate: assert property (op_req_valid_o
		&& op_req_o.kind == fpac_pkg::FPAC_K_CHIP |-> lvl == 4'h0)
		else $error("chip erase while protected");
	chk_array_gate: assert property (array_read_en_o
		== (!busy_i && !otp_mode_o)) else $error("array gate wrong");
	chk_off_deselect: assert property (cs_n_i |-> !so_oe_o)
		else $error("output driven while deselected");
	chk_pulse_once: assert property ((op_req_valid_o || cmd_reject_o)
		|-> $past(cs_n_i, 2) && !(op_req_valid_o && cmd_reject_o)
		##1 !(op_req_valid_o || cmd_reject_o))
		else $error("bad request or refusal pulse");
	chk_latch_used: assert property (op_req_valid_o
		|-> $past(status_o[1]) ##1 !status_o[1])
		else $error("change without latch or latch kept");
	chk_block_hit: assert property (op_req_valid_o && !op_req_o.otp
		&& op_req_o.kind != fpac_pkg::FPAC_K_CHIP
		|-> !prot_mask_o[op_req_o.addr[19:16]])
		else $error("change inside protected block");
	chk_otp_row: assert property (op_req_valid_o && op_req_o.otp
		|-> op_req_o.kind == fpac_pkg::FPAC_K_PROG
		&& !security_o[op_req_o.addr[`FPAC_OTP_ROW_BIT] ? 0 : 1])
		else $error("bad otp request");
	chk_factory_bit: assert property ($past(factory_lock_i)
		== factory_lock_i |-> security_o[0] == factory_lock_i)
		else $error("factory lock bit wrong");
endmodule : fpac_access_ctl_asserts

bind fpac_access_ctl fpac_access_ctl_asserts #(.NUM_BLOCKS(NUM_BLOCKS))
	fpac_access_ctl_asserts_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
	.cs_n_i(cs_n_i), .busy_i(busy_i), .factory_lock_i(factory_lock_i),
	.so_oe_o(so_oe_o), .op_req_o(op_req_o), .op_req_valid_o(op_req_valid_o),
	.cmd_reject_o(cmd_reject_o), .array_read_en_o(array_read_en_o),
	.otp_mode_o(otp_mode_o), .status_o(status_o), .security_o(security_o),
	.prot_mask_o(prot_mask_o));
`default_nettype wire

// ---- tb/fpac_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module fpac_host_model (
	input wire logic so_i, // device serial out
	input wire logic so_oe_i, // device output enable
	output logic sclk_o, // serial clock, 48 ns
	output logic cs_n_o, // chip select
	output logic si_o // serial data to device
);
	// ****
	// frame driver
	// ****
	logic mode3; // clock idles high when set
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
		mode3 = 1'b0;
	end
	// clock only runs inside frames; x extra clocks follow the bytes
	task automatic frame(input logic [7:0] b[$], input int x,
		output logic [7:0] rd);
		logic [7:0] d;
		rd = 8'h00;
		sclk_o = mode3;
		#7;
		cs_n_o = 1'b0;
		#24;
		for (int i = 0; i < b.size() * 8 + x; i++) begin
			d = (i < b.size() * 8) ? b[i / 8] : 8'h00;
			sclk_o = 1'b0;
			si_o = d[7 - i % 8];
			#24;
			sclk_o = 1'b1;
			rd = {rd[6:0], so_oe_i ? so_i : 1'bx};
			#24;
		end
		sclk_o = mode3;
		#24;
		cs_n_o = 1'b1;
		si_o = ~si_o; // released line must not keep its value
		#48;
	endtask : frame
endmodule : fpac_host_model
`default_nettype wire

// ---- tb/test_flash_protect_access_ctl.sv ----
`timescale 1ns/10ps
`default_nettype none

module test_flash_protect_access_ctl;
	logic clk, rst_n, sclk, cs_n, si, wp_n, busy, flock, so, so_oe;
	logic vld, rej, aren, otpm, act, sb, seen_sb, seen_act, cnv;
	logic [7:0] st, sec, rd;
	logic [15:0] mask;
	fpac_pkg::fpac_op_req_t req, last;
	int errors, num_checks, n_ok, n_rej;
	fpac_access_ctl fpac_access_ctl_i (.sys_clk_i(clk), .reset_n_i(rst_n),
		.sclk_i(sclk), .cs_n_i(cs_n), .si_i(si), .wp_n_i(wp_n),
		.busy_i(busy), .factory_lock_i(flock), .cust_lock_nv_i(cnv),
		.so_o(so), .so_oe_o(so_oe), .op_req_o(req), .op_req_valid_o(vld),
		.cmd_reject_o(rej), .array_read_en_o(aren), .otp_mode_o(otpm),
		.status_o(st), .security_o(sec), .prot_mask_o(mask),
		.mode_active_o(act), .standby_o(sb));
	fpac_host_model fpac_host_model_i (.so_i(so), .so_oe_i(so_oe),
		.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si));
	// ****
	// clock and pulse watchers
	// ****
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// one-cycle pulses are counted here so no frame can miss them
	always @(negedge clk) begin
		if (vld === 1'b1) begin
			n_ok++;
			last = req;
		end
		if (rej === 1'b1) n_rej++;
		if (sb === 1'b1) seen_sb = 1'b1;
		if (act === 1'b1) seen_act = 1'b1;
	end
	task cmp1(input logic g, input logic e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("ERROR %0t: flag %b expected %b", $time, g, e);
		end
	endtask : cmp1
	task cmp8(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("ERROR %0t: byte %h expected %h", $time, g, e);
		end
	endtask : cmp8
	task cmp24(input logic [23:0] g, input logic [23:0] e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("ERROR %0t: word %h expected %h", $time, g, e);
		end
	endtask : cmp24
	// ****
	// frame helpers
	// ****
	task fr(input logic [7:0] b[$], input int x);
		fpac_host_model_i.frame(b, x, rd);
		repeat (6) @(posedge clk);
	endtask : fr
	task ex(input logic [7:0] b[$], input int x, input logic e);
		int o;
		int r;
		o = n_ok;
		r = n_rej;
		fr(b, x);
		cmp1(n_ok != o, e);
		cmp1(n_rej != r, !e);
	endtask : ex
	task wen();
		fr('{8'h06}, 0);
	endtask : wen
	task set_st(input logic [3:0] l, input logic t, input logic g);
		wen();
		fr('{8'h01, {g, 1'b0, l, 2'b00}, {4'h0, t, 3'h0}}, 0);
	endtask : set_st
	// program always carries one data byte to make a legal length
	task ae(input logic [7:0] op, input logic [23:0] a, input logic e,
		input logic [7:0] k, input logic o);
		logic [7:0] q[$];
		q = '{op, a[23:16], a[15:8], a[7:0]};
		if (op == 8'h02) q.push_back(8'h5a);
		wen();
		ex(q, 0, e);
		if (e) begin
			cmp8({5'h00, last.kind}, k);
			cmp24(last.addr, a);
			cmp1(last.otp, o);
		end
	endtask : ae
	function automatic logic [15:0] exp_mask(input logic [3:0] l,
		input logic t);
		int n;
		n = (l == 4'h0) ? 0 : (l > 4'h4) ? 16 : 1 << (l - 4'h1);
		for (int i = 0; i < 16; i++) begin
			exp_mask[i] = t ? i < n : i >= 16 - n;
		end
	endfunction : exp_mask
	// ****
	// scenarios
	// ****
	task t_levels();
		logic [4:0] i5;
		for (int i = 0; i < 32; i++) begin
			i5 = i[4:0];
			fpac_host_model_i.mode3 = i5[4];
			set_st(i5[3:0], i5[4], 1'b0);
			cmp24({8'h00, mask}, {8'h00, exp_mask(i5[3:0], i5[4])});
			fr('{8'h05}, 8);
			cmp8(rd, {2'b00, i5[3:0], 2'b00});
			fr('{8'h15}, 8);
			cmp8(rd, {4'h0, i5[4], 3'h0});
		end
		fpac_host_model_i.mode3 = 1'b0;
		$display("levels done");
	endtask : t_levels
	task t_erase();
		set_st(4'h1, 1'b0, 1'b0);
		wen();
		ex('{8'h60}, 0, 1'b0);
		set_st(4'h0, 1'b0, 1'b0);
		ex('{8'hc7}, 0, 1'b0);
		wen();
		ex('{8'h60}, 3, 1'b0);
		wen();
		ex('{8'hc7}, 0, 1'b1);
		cmp8({5'h00, last.kind}, 8'h05);
		set_st(4'h1, 1'b0, 1'b0);
		ae(8'hd8, 24'h0f0000, 1'b0, 8'h00, 1'b0);
		ae(8'hd8, 24'h0e0000, 1'b1, 8'h04, 1'b0);
		ae(8'h20, 24'h0f1000, 1'b0, 8'h00, 1'b0);
		ae(8'h52, 24'h010000, 1'b1, 8'h03, 1'b0);
		ae(8'h02, 24'h0e0100, 1'b1, 8'h01, 1'b0);
		@(negedge clk) busy = 1'b1;
		@(posedge clk) cmp1(aren, 1'b0);
		ae(8'h20, 24'h010000, 1'b0, 8'h00, 1'b0);
		@(negedge clk) busy = 1'b0;
		ae(8'h20, 24'h010000, 1'b1, 8'h02, 1'b0);
		$display("erase done");
	endtask : t_erase
	task t_otp();
		fr('{8'hb1}, 0);
		cmp1(otpm, 1'b1);
		cmp1(aren, 1'b0);
		ae(8'h02, 24'h000010, 1'b1, 8'h01, 1'b1);
		ae(8'h20, 24'h000000, 1'b0, 8'h00, 1'b0);
		@(negedge clk) flock = 1'b1;
		repeat (3) @(posedge clk);
		cmp1(sec[0], 1'b1);
		ae(8'h02, 24'h000200, 1'b0, 8'h00, 1'b0);
		wen();
		fr('{8'h2f}, 0);
		cmp1(sec[1], 1'b1);
		ae(8'h02, 24'h000010, 1'b0, 8'h00, 1'b0);
		fr('{8'h2b}, 8);
		cmp8(rd, 8'h03);
		fr('{8'hc1}, 0);
		cmp1(otpm, 1'b0);
		$display("otp done");
	endtask : t_otp
	task t_modes();
		seen_sb = 1'b0;
		seen_act = 1'b0;
		fr('{8'hff}, 8);
		cmp8(rd, 8'hxx);
		cmp1(seen_sb, 1'b1);
		cmp1(seen_act, 1'b0);
		fr('{8'h05}, 8);
		cmp1(seen_act, 1'b1);
		cmp1(sb, 1'b0);
		wen();
		cmp1(st[1], 1'b1);
		fr('{8'h04}, 0);
		cmp1(st[1], 1'b0);
		set_st(4'h0, 1'b0, 1'b1);
		@(negedge clk) wp_n = 1'b0;
		set_st(4'h2, 1'b0, 1'b1);
		cmp8({4'h0, st[5:2]}, 8'h00);
		@(negedge clk) wp_n = 1'b1;
		set_st(4'h2, 1'b0, 1'b0);
		cmp8({4'h0, st[5:2]}, 8'h02);
		$display("modes done");
	endtask : t_modes
	// mid-run reset reloads the stored customer lock
	task t_reset();
		@(negedge clk) {cnv, rst_n} = 2'b10;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		cmp8(sec, 8'h03);
		fr('{8'hb1}, 0);
		ae(8'h02, 24'h000010, 1'b0, 8'h00, 1'b0);
		$display("reset done");
	endtask : t_reset
	task conclude();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : conclude
	// the guard stops a hung run and counts it as a mismatch
	initial begin
		#400000;
		errors++;
		conclude();
	end
	initial begin
		{rst_n, wp_n, busy, flock, cnv, errors, num_checks, n_ok, n_rej} = '0;
		wp_n = 1'b1;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		cmp8(st, 8'h00);
		cmp24({8'h00, mask}, 24'h000000);
		cmp8(sec, 8'h00);
		t_levels();
		t_erase();
		t_otp();
		t_modes();
		t_reset();
		conclude();
	end
endmodule : test_flash_protect_access_ctl
`default_nettype wire
